// >>> src/hec_pkg.sv
/*
  constants, fault/cause types and register map for the hw error and exception cause unit.
  assumes a 32-bit apb slave port and one core clock.
*/
package hec_pkg;
  // cause codes (hardware error, 5 bits)
  localparam logic [4:0] HEC_HW_SYSREG = 5'h02;
  localparam logic [4:0] HEC_HW_EXTMEM = 5'h03;
  localparam logic [4:0] HEC_HW_PERFMON = 5'h12;
  localparam logic [4:0] HEC_HW_RAISE5 = 5'h18;
  localparam logic [4:0] HEC_HW_NONE = 5'h00;
  // exception cause codes (6 bits)
  localparam logic [5:0] HEC_EX_STEP = 6'h10;
  localparam logic [5:0] HEC_EX_TRACE = 6'h11;
  localparam logic [5:0] HEC_EX_UNDEF = 6'h21;
  localparam logic [5:0] HEC_EX_ILLCOMB = 6'h22;
  localparam logic [5:0] HEC_EX_DPROT = 6'h23;
  localparam logic [5:0] HEC_EX_DMISAL = 6'h24;
  localparam logic [5:0] HEC_EX_UNRECOV = 6'h25;
  localparam logic [5:0] HEC_EX_DMISS = 6'h26;
  localparam logic [5:0] HEC_EX_DMULTI = 6'h27;
  localparam logic [5:0] HEC_EX_WATCH = 6'h28;
  localparam logic [5:0] HEC_EX_IACCESS = 6'h29;
  localparam logic [5:0] HEC_EX_IMISAL = 6'h2a;
  localparam logic [5:0] HEC_EX_IPROT = 6'h2b;
  localparam logic [5:0] HEC_EX_IMISS = 6'h2c;
  localparam logic [5:0] HEC_EX_IMULTI = 6'h2d;
  localparam logic [5:0] HEC_EX_SUPV = 6'h2e;
  localparam logic [5:0] HEC_EX_NONE = 6'h00;
  // apb register byte offsets
  localparam logic [11:0] HEC_OFF_STATUS = 12'h000;
  localparam logic [11:0] HEC_OFF_CTRL = 12'h004;
  localparam logic [11:0] HEC_OFF_EXRET = 12'h008;
  localparam logic [11:0] HEC_OFF_HWRET = 12'h00c;
  // status fields
  localparam int HEC_ST_EXC_LSB = 0;
  localparam int HEC_ST_HW_LSB = 14;
  localparam int HEC_ST_HWREQ_BIT = 31;
  // control fields
  localparam int HEC_CT_STEP_BIT = 0;
  localparam int HEC_CT_TRACE_BIT = 1;
  localparam int HEC_CT_WSEL_LSB = 2;
  localparam logic [31:0] HEC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HEC_CTRL_MASK = 32'h0000_003f;

  // per-data-generator fault set
  typedef struct packed {
    logic multi;
    logic misal;
    logic prot;
    logic miss;
  } hec_dag_flt_t;

  // faults reported for the instruction trying to finish
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic if_multi;
    logic if_misal;
    logic if_prot;
    logic if_miss;
    logic if_access;
    logic watch;
    logic undef;
    logic illcomb;
    logic supv;
    hec_dag_flt_t dag_first;
    hec_dag_flt_t dag_second;
    logic force_exc;
    logic [3:0] force_code;
    logic trace_full;
  } hec_instr_t;

  // hardware error sources, one level each
  typedef struct packed {
    logic sysreg;
    logic extmem;
    logic perfmon;
    logic raise5;
  } hec_hw_src_t;

  typedef enum logic [1:0] {
    HEC_CLS_NONE = 2'b01,
    HEC_CLS_TAKEN = 2'b10
  } hec_cls_t;
endpackage

// >>> src/hec_unit.sv
/*
  hw error and exception cause unit: records hardware error causes, picks
  the exception of highest priority, decides commit and the return address.
  assumes fault reports are synchronous to pclk and held for the cycle that
  the instruction tries to finish; apb master per amba apb.
*/
// Notes on behaviour
// RULE1: hw cause keeps latest error, no queue
// RULE2: hw request high while any error active
// RULE3: software writes never clear hw status
// RULE4: hw error does not capture faulting pc
// RULE5: core errors local; dma errors to both
// RULE6: 0x02 system register, 0x03 external memory
// RULE7: 0x12 perf overflow, 0x18 raise five
// RULE8: exception taken as instruction finishes
// RULE9: service exception commits, returns next pc
// RULE10: error exception aborts, returns own pc
// RULE11: exception cause written on every exception
// RULE12: nested exception is double fault, own pc
// RULE13: force instruction gives four cause bits
// RULE14: single step gives cause 0x10
// RULE15: trace overflow 0x11 only when enabled
// RULE16: undefined 0x21, illegal combination 0x22
// RULE17: data faults 0x23 0x24 0x26 0x27
// RULE18: watchpoint 0x28 only when selected
// RULE19: fetch faults 0x2a 0x2b 0x2c 0x2d
// RULE20: user supervisor resource use gives 0x2e
// RULE21: only highest priority registered per pass
// RULE22: fixed priority order of exceptions
// RULE23: nested exception not taken, cause 0x25
// RULE24: hw cause field is five bits
// RULE25: external error held while condition lasts
`timescale 1ns/100ps
module hec_unit
  import hec_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pipeline
  input wire hec_pkg::hec_instr_t instr,
  input wire logic in_handler,
  output logic exc_taken,
  output logic instr_commit,
  output logic [5:0] exception_cause,
  output logic [31:0] exception_return_addr,
  // hardware errors
  input wire hec_pkg::hec_hw_src_t hw_core_src,
  input wire hec_pkg::hec_hw_src_t hw_dma_src,
  input wire logic [31:0] hw_pc,
  output logic [4:0] hw_error_cause,
  output logic hw_error_interrupt,
  output logic hw_to_peer
);
  import hec_pkg::*;

  logic [31:0] ctrl_r;
  logic [31:0] interrupt_return_addr_r;
  logic [5:0] cause_nxt;
  logic service_nxt;
  logic exc_nxt;
  logic watch_en;
  logic [4:0] hw_nxt;
  logic hw_any;
  hec_hw_src_t hw_all;
  hec_cls_t cls_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // exception priority
  assign watch_en = |ctrl_r[HEC_CT_WSEL_LSB +: 4];

  always_comb
  begin
    cause_nxt = HEC_EX_NONE;
    service_nxt = 1'b0;
    exc_nxt = 1'b1;
    if (in_handler) cause_nxt = HEC_EX_UNRECOV; // RULE22 RULE23
    else if (instr.if_multi) cause_nxt = HEC_EX_IMULTI; // RULE19 RULE22
    else if (instr.if_misal) cause_nxt = HEC_EX_IMISAL; // RULE19
    else if (instr.if_prot) cause_nxt = HEC_EX_IPROT; // RULE19
    else if (instr.if_miss) cause_nxt = HEC_EX_IMISS; // RULE19
    else if (instr.if_access) cause_nxt = HEC_EX_IACCESS; // RULE22
    else if (instr.watch && watch_en) cause_nxt = HEC_EX_WATCH; // RULE18
    else if (instr.undef) cause_nxt = HEC_EX_UNDEF; // RULE16
    else if (instr.illcomb) cause_nxt = HEC_EX_ILLCOMB; // RULE16
    else if (instr.supv) cause_nxt = HEC_EX_SUPV; // RULE20
    else if (instr.dag_first.multi) cause_nxt = HEC_EX_DMULTI; // RULE17
    else if (instr.dag_first.misal) cause_nxt = HEC_EX_DMISAL; // RULE17
    else if (instr.dag_first.prot) cause_nxt = HEC_EX_DPROT; // RULE17
    else if (instr.dag_first.miss) cause_nxt = HEC_EX_DMISS; // RULE17
    else if (instr.dag_second.multi) cause_nxt = HEC_EX_DMULTI; // RULE17
    else if (instr.dag_second.misal) cause_nxt = HEC_EX_DMISAL;
    else if (instr.dag_second.prot) cause_nxt = HEC_EX_DPROT;
    else if (instr.dag_second.miss) cause_nxt = HEC_EX_DMISS;
    else if (instr.force_exc)
    begin
      cause_nxt = {2'b00, instr.force_code}; // RULE13
      service_nxt = 1'b1;
    end
    else if (ctrl_r[HEC_CT_STEP_BIT])
    begin
      cause_nxt = HEC_EX_STEP; // RULE14
      service_nxt = 1'b1;
    end
    else if (instr.trace_full && ctrl_r[HEC_CT_TRACE_BIT])
    begin
      cause_nxt = HEC_EX_TRACE; // RULE15
      service_nxt = 1'b1;
    end
    else exc_nxt = 1'b0;
    // a handler only counts when something actually faulted
    if (in_handler && !(instr.if_multi || instr.if_misal || instr.if_prot || instr.if_miss ||
        instr.if_access || (instr.watch && watch_en) || instr.undef || instr.illcomb ||
        instr.supv || (|instr.dag_first) || (|instr.dag_second) || instr.force_exc ||
        ctrl_r[HEC_CT_STEP_BIT] || (instr.trace_full && ctrl_r[HEC_CT_TRACE_BIT])))
    begin
      exc_nxt = 1'b0;
      cause_nxt = HEC_EX_NONE;
    end
    exc_nxt = exc_nxt && instr.valid;
  end

  assign cls_nxt = exc_nxt ? HEC_CLS_TAKEN : HEC_CLS_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // exception registration (one per pass, re-execution gives the next)
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exc_taken <= 1'b0;
      instr_commit <= 1'b0;
      exception_cause <= HEC_EX_NONE;
      exception_return_addr <= 32'h0000_0000;
    end
    else
    begin
      exc_taken <= (cls_nxt == HEC_CLS_TAKEN) && !in_handler; // RULE8 RULE21 RULE23
      instr_commit <= instr.valid && (!exc_nxt || (service_nxt && !in_handler)); // RULE9 RULE10
      if (exc_nxt)
      begin
        exception_cause <= cause_nxt; // RULE11
        exception_return_addr <= (service_nxt && !in_handler) ? instr.next_pc : instr.pc; // RULE9 RULE10 RULE12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hardware error cause, last source wins
  assign hw_all = hw_core_src | hw_dma_src;
  assign hw_any = |hw_all;

  always_comb
  begin
    hw_nxt = hw_error_cause;
    // fixed order: later assignment wins when simultaneous
    if (hw_all.sysreg) hw_nxt = HEC_HW_SYSREG; // RULE6
    if (hw_all.extmem) hw_nxt = HEC_HW_EXTMEM; // RULE6
    if (hw_all.perfmon) hw_nxt = HEC_HW_PERFMON; // RULE7
    if (hw_all.raise5) hw_nxt = HEC_HW_RAISE5; // RULE7
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_error_cause <= HEC_HW_NONE;
      hw_error_interrupt <= 1'b0;
      hw_to_peer <= 1'b0;
    end
    else
    begin
      hw_error_cause <= hw_nxt; // RULE1 RULE3 RULE24
      hw_error_interrupt <= hw_any; // RULE2 RULE25
      hw_to_peer <= |hw_dma_src; // RULE5
    end
  end

  // hw return address follows the interrupted pc, not the faulting one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) interrupt_return_addr_r <= 32'h0000_0000;
    else if (hw_any && !hw_error_interrupt) interrupt_return_addr_r <= hw_pc; // RULE4
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  logic acc;
  assign acc = psel && !penable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) ctrl_r <= HEC_CTRL_RST;
    else if (psel && penable && pwrite && paddr == HEC_OFF_CTRL) ctrl_r <= pwdata & HEC_CTRL_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (acc)
      begin
        unique case (paddr)
          HEC_OFF_STATUS: prdata <= {hw_error_interrupt, 12'h000, hw_error_cause, 8'h00,
                                     exception_cause};
          HEC_OFF_CTRL: prdata <= ctrl_r;
          HEC_OFF_EXRET: prdata <= exception_return_addr;
          HEC_OFF_HWRET: prdata <= interrupt_return_addr_r;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  hw_req_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    hw_any |=> hw_error_interrupt) else $error("hw request dropped"); // RULE2
  hw_req_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    !hw_any |=> !hw_error_interrupt) else $error("hw request without error"); // RULE2
  hw_raise_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    hw_all.raise5 |=> hw_error_cause == 5'h18) else $error("raise cause wrong"); // RULE7
  hw_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !hw_any |=> $stable(hw_error_cause)) else $error("hw cause changed"); // RULE3
  svc_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (instr.valid && !in_handler && exc_nxt && service_nxt) |=>
    (instr_commit && exception_return_addr == $past(instr.next_pc)))
    else $error("service return wrong"); // RULE9
  err_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    (instr.valid && exc_nxt && !service_nxt) |=>
    (!instr_commit && exception_return_addr == $past(instr.pc)))
    else $error("error return wrong"); // RULE10
  nest_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (instr.valid && exc_nxt && in_handler) |=> (!exc_taken && exception_cause == 6'h25))
    else $error("double fault wrong"); // RULE23
  step_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (exc_nxt && !in_handler && cause_nxt == 6'h10) |=> exc_taken && exception_cause == 6'h10)
    else $error("single step cause wrong"); // RULE14
  fetch_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    (instr.valid && !in_handler && instr.if_multi) |=> exception_cause == 6'h2d)
    else $error("fetch priority wrong"); // RULE22
  peer_dma_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|hw_dma_src) |=> hw_to_peer) else $error("dma error not sent"); // RULE5

  ////////////////////////////////////////////////////////////////////////////
  // hardware error codes and ownership
  hw_sys_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (hw_all.sysreg && !hw_all.extmem && !hw_all.perfmon && !hw_all.raise5) |=>
    hw_error_cause == HEC_HW_SYSREG) else $error("system register cause wrong");
  hw_ext_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (hw_all.extmem && !hw_all.perfmon && !hw_all.raise5) |=>
    hw_error_cause == HEC_HW_EXTMEM) else $error("external memory cause wrong");
  hw_perf_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (hw_all.perfmon && !hw_all.raise5) |=> hw_error_cause == HEC_HW_PERFMON)
    else $error("overflow cause wrong");
  hw_cause_legal_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE24
    hw_error_cause == HEC_HW_NONE || hw_error_cause == HEC_HW_SYSREG ||
    hw_error_cause == HEC_HW_EXTMEM || hw_error_cause == HEC_HW_PERFMON ||
    hw_error_cause == HEC_HW_RAISE5) else $error("reserved hw cause");
  hw_ret_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    hw_error_interrupt |=> $stable(interrupt_return_addr_r))
    else $error("hw return moved while pending");
  core_local_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    ((|hw_core_src) && !(|hw_dma_src)) |=> !hw_to_peer)
    else $error("core error sent to peer");

  ////////////////////////////////////////////////////////////////////////////
  // exception outcome
  no_spurious_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    !instr.valid |=> (!exc_taken && !instr_commit))
    else $error("outcome without instruction");
  cause_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    !exc_nxt |=> ($stable(exception_cause) && $stable(exception_return_addr)))
    else $error("cause changed without exception");
  nest_ret_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    (instr.valid && exc_nxt && in_handler) |=>
    (!instr_commit && exception_return_addr == $past(instr.pc)))
    else $error("double fault return wrong");
  force_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    (instr.valid && !in_handler && instr.force_exc && service_nxt) |=>
    (exc_taken && instr_commit && exception_cause[3:0] == $past(instr.force_code)))
    else $error("force cause wrong");
  trace_en_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    (exc_taken && exception_cause == HEC_EX_TRACE) |-> $past(ctrl_r[HEC_CT_TRACE_BIT]))
    else $error("trace exception while disabled");
  undef_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    (instr.valid && !in_handler && instr.undef && !instr.if_multi && !instr.if_misal &&
    !instr.if_prot && !instr.if_miss && !instr.if_access && !instr.watch) |=>
    (exception_cause == HEC_EX_UNDEF && !instr_commit)) else $error("undefined cause wrong");
  watch_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    (exc_taken && exception_cause == HEC_EX_WATCH) |-> $past(watch_en))
    else $error("watchpoint exception unselected");
  fetch_access_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
    (instr.valid && !in_handler && instr.if_access && !instr.if_multi && !instr.if_misal &&
    !instr.if_prot && !instr.if_miss) |=> exception_cause == HEC_EX_IACCESS)
    else $error("fetch access cause wrong");
  nest_not_taken_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
    exc_taken |-> exception_cause != HEC_EX_UNRECOV)
    else $error("unrecoverable event taken");
  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held too long");

  svc_cov_c: cover property (@(posedge pclk) exc_taken && instr_commit);
  err_cov_c: cover property (@(posedge pclk) exc_taken && !instr_commit);
  nest_cov_c: cover property (@(posedge pclk) exception_cause == 6'h25);
  hw_cov_c: cover property (@(posedge pclk) $rose(hw_error_interrupt));
  peer_cov_c: cover property (@(posedge pclk) hw_to_peer);
endmodule

// >>> tb/hec_err_src.sv
/*
  error source model: the bus controller and dma that raise the core and dma error lines.
  assumes the pclk and presetn of the unit under test.
*/
`timescale 1ns/100ps
module hec_err_src
  import hec_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // failed transfer conditions from the bench
  input wire hec_pkg::hec_hw_src_t core_fail,
  input wire hec_pkg::hec_hw_src_t dma_fail,
  // error lines to the unit
  output hec_pkg::hec_hw_src_t hw_core_src,
  output hec_pkg::hec_hw_src_t hw_dma_src
);
  ////////////////////////////////////////////////////////////////////////////////
  // each line stays up for as long as its condition persists
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_core_src <= '0;
      hw_dma_src <= '0;
    end
    else
    begin
      hw_core_src <= core_fail;
      hw_dma_src <= dma_fail;
    end
  end
endmodule

// >>> tb/tb_top.sv
/*
  testbench of the hw error and exception cause unit: apb and pipeline sequences.
  assumes the error source model hec_err_src.
*/
`timescale 1ns/100ps
module tb_top;
  import hec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, in_handler, er;
  logic pready, pslverr, exc_taken, instr_commit, hw_error_interrupt, hw_to_peer;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, hw_pc, rd, a, exception_return_addr;
  logic [5:0] exception_cause;
  logic [4:0] hw_error_cause;
  logic [5:0] cz [17];
  hec_instr_t instr, t;
  hec_hw_src_t core_req, dma_req, hw_core_src, hw_dma_src;
  int err_count, compares, k, j;

  hec_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr, .in_handler, .exc_taken, .instr_commit, .exception_cause,
    .exception_return_addr, .hw_core_src, .hw_dma_src, .hw_pc, .hw_error_cause,
    .hw_error_interrupt, .hw_to_peer);
  hec_err_src err_u (.pclk, .presetn, .core_fail(core_req), .dma_fail(dma_req),
    .hw_core_src, .hw_dma_src);

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic summarize();
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer; read data taken at the completing edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 64)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 64)
    begin
      err_count++;
      $display("MISMATCH at %0t: no ready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic hec_instr_t mk(input int n);
    hec_instr_t f;
    f = '0;
    case (n)
      0: f.if_multi = 1'b1;
      1: f.if_misal = 1'b1;
      2: f.if_prot = 1'b1;
      3: f.if_miss = 1'b1;
      4: f.if_access = 1'b1;
      5: f.watch = 1'b1;
      6: f.undef = 1'b1;
      7: f.illcomb = 1'b1;
      8: f.supv = 1'b1;
      9, 10, 11, 12: f.dag_first = 4'(4'b1000 >> (n - 9));
      default: f.dag_second = 4'(4'b1000 >> (n - 13));
    endcase
    return f;
  endfunction

  function automatic hec_instr_t op(input hec_instr_t f, input logic [31:0] p);
    f.valid = 1'b1;
    f.pc = p;
    f.next_pc = p + 32'h0000_0004;
    return f;
  endfunction

  // one instruction finishing, then its outcome a cycle later
  task automatic run(input hec_instr_t f, input logic tk, input logic cm,
    input logic [5:0] c, input logic [31:0] r);
    @(posedge pclk);
    instr <= f;
    @(posedge pclk);
    instr <= '0;
    #1;
    chk(exc_taken, tk);
    chk(instr_commit, cm);
    chk(exception_cause, c);
    chk(exception_return_addr, r);
  endtask

  task automatic hw(input hec_hw_src_t c, input hec_hw_src_t d, input logic q, input logic p);
    @(posedge pclk);
    core_req <= c;
    dma_req <= d;
    repeat (3) @(posedge pclk);
    #1;
    chk(hw_error_interrupt, q);
    chk(hw_to_peer, p);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, in_handler} = 4'h0;
    paddr = '0;
    pwdata = '0;
    instr = '0;
    hw_pc = 32'h0000_2000;
    core_req = '0;
    dma_req = '0;
    err_count = 0;
    compares = 0;
    cz = '{6'h2d, 6'h2a, 6'h2b, 6'h2c, 6'h29, 6'h28, 6'h21, 6'h22, 6'h2e,
      6'h27, 6'h24, 6'h23, 6'h26, 6'h27, 6'h24, 6'h23, 6'h26};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, HEC_OFF_STATUS, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, HEC_OFF_CTRL, '0);
    chk(rd, HEC_CTRL_RST);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk(er, 1'b1);
    apb(1'b1, HEC_OFF_CTRL, 32'hffff_ffff);
    apb(1'b0, HEC_OFF_CTRL, '0);
    chk(rd, HEC_CTRL_MASK);
    apb(1'b1, HEC_OFF_CTRL, 32'h0000_0004);
    for (k = 0; k < 17; k++)
    begin
      t = '0;
      for (j = k; j < 17; j++)
        t = t | mk(j);
      a = 32'h0000_1000 + 32'(k) * 32'h0000_0010;
      run(op(t, a), 1'b1, 1'b0, cz[k], a);
    end
    apb(1'b0, HEC_OFF_STATUS, '0);
    chk(rd, 32'h0000_0026);
    apb(1'b0, HEC_OFF_EXRET, '0);
    chk(rd, a);
    @(posedge pclk);
    in_handler <= 1'b1;
    run(op(mk(6), 32'h0000_3000), 1'b0, 1'b0, HEC_EX_UNRECOV, 32'h0000_3000);
    @(posedge pclk);
    in_handler <= 1'b0;
    apb(1'b1, HEC_OFF_CTRL, 32'h0000_0000);
    run(op(mk(5), 32'h0000_3100), 1'b0, 1'b1, HEC_EX_UNRECOV, 32'h0000_3000);
    t = '0;
    t.trace_full = 1'b1;
    run(op(t, 32'h0000_3200), 1'b0, 1'b1, HEC_EX_UNRECOV, 32'h0000_3000);
    apb(1'b1, HEC_OFF_CTRL, 32'h0000_0002);
    run(op(t, 32'h0000_3200), 1'b1, 1'b1, HEC_EX_TRACE, 32'h0000_3204);
    apb(1'b1, HEC_OFF_CTRL, 32'h0000_0001);
    t = '0;
    t.force_exc = 1'b1;
    t.force_code = 4'ha;
    run(op(t, 32'h0000_3300), 1'b1, 1'b1, 6'h0a, 32'h0000_3304);
    run(op('0, 32'h0000_3400), 1'b1, 1'b1, HEC_EX_STEP, 32'h0000_3404);
    apb(1'b1, HEC_OFF_CTRL, 32'h0000_0000);
    hw(4'b1000, 4'b0000, 1'b1, 1'b0);
    chk(hw_error_cause, HEC_HW_SYSREG);
    apb(1'b0, HEC_OFF_HWRET, '0);
    chk(rd, 32'h0000_2000);
    apb(1'b1, HEC_OFF_STATUS, 32'h0000_0000);
    apb(1'b0, HEC_OFF_STATUS, '0);
    chk(rd, 32'h8000_8010);
    hw(4'b1010, 4'b0000, 1'b1, 1'b0);
    chk(hw_error_cause, HEC_HW_PERFMON);
    hw(4'b1000, 4'b0000, 1'b1, 1'b0);
    hw(4'b1111, 4'b0000, 1'b1, 1'b0);
    chk(hw_error_cause, HEC_HW_RAISE5);
    hw(4'b0000, 4'b0100, 1'b1, 1'b1);
    chk(hw_error_cause, HEC_HW_EXTMEM);
    hw(4'b0000, 4'b0000, 1'b0, 1'b0);
    summarize();
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    err_count++;
    summarize();
  end
endmodule
